// ---- rtl/trigger_qualification_holdoff.sv ----
// Trigger qualification, run modes and holdoff acceptance
`timescale 1ns/1ps
`include "trig_map.svh"
module trigger_qualification_holdoff #(
  parameter int NA = `ANA_CHANNELS,
  parameter int ND = `DIG_CHANNELS,
  parameter int NC = `CTX_COUNT,
  parameter int W  = 32
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic [NA-1:0]           ana_in,
  input  wire logic [ND-1:0]           dig_in,
  input  wire logic                    cfg_we,
  input  wire logic [1:0]              cfg_ctx,
  input  wire trig_pkg::trig_type_t    cfg_type,
  input  wire logic [2*NA-1:0]         cfg_ana_req,
  input  wire logic [2*ND-1:0]         cfg_dig_req,
  input  wire logic                    cfg_ana_or,
  input  wire logic                    cfg_dig_or,
  input  wire trig_pkg::edge_sel_t     cfg_edge,
  input  wire logic [1:0]              cfg_clk_ch,
  input  wire trig_pkg::pat_src_t      cfg_pat_src,
  input  wire logic [1:0]              active_ctx,
  input  wire trig_pkg::run_mode_t     run_mode,
  input  wire logic                    force_req,
  input  wire logic                    holdoff_bypass,
  input  wire trig_pkg::holdoff_mode_t holdoff_mode,
  input  wire logic [W-1:0]            holdoff_time_cyc,
  input  wire logic [W-1:0]            holdoff_events,
  input  wire logic [W-1:0]            holdoff_min_cyc,
  input  wire logic [W-1:0]            holdoff_max_cyc,
  input  wire logic [W-1:0]            hscale_cyc,
  input  wire logic                    scale_we,
  input  wire logic [15:0]             scale_fx,
  input  wire logic [W-1:0]            auto_timeout_cyc,
  output logic                         trig_out,
  output logic                         trig_forced,
  output logic                         holdoff_busy,
  output logic                         qual_state
);
  // ****************************************
  // Per-context settings and the shared scale factor
  // ****************************************
  trig_pkg::trig_type_t type_q    [NC];
  logic [2*NA-1:0]      ana_req_q [NC];
  logic [2*ND-1:0]      dig_req_q [NC];
  logic                 ana_or_q  [NC];
  logic                 dig_or_q  [NC];
  trig_pkg::edge_sel_t  edge_q    [NC];
  logic [1:0]           clk_ch_q  [NC];
  trig_pkg::pat_src_t   src_q     [NC];
  logic [15:0]          scale_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < NC; c++)
      begin
        type_q[c]    <= trig_pkg::TRIG_STATE;
        ana_req_q[c] <= '0;
        dig_req_q[c] <= '0;
        ana_or_q[c]  <= 1'b0;
        dig_or_q[c]  <= 1'b0;
        edge_q[c]    <= trig_pkg::EDGE_RISE;
        clk_ch_q[c]  <= 2'h0;
        src_q[c]     <= trig_pkg::SRC_ANALOG;
      end
    end
    else if (cfg_we && 32'(cfg_ctx) < NC)
    begin
      type_q[cfg_ctx]    <= cfg_type;
      ana_req_q[cfg_ctx] <= cfg_ana_req;
      dig_req_q[cfg_ctx] <= cfg_dig_req;
      ana_or_q[cfg_ctx]  <= cfg_ana_or;
      dig_or_q[cfg_ctx]  <= cfg_dig_or;
      edge_q[cfg_ctx]    <= cfg_edge;
      clk_ch_q[cfg_ctx]  <= cfg_clk_ch;
      src_q[cfg_ctx]     <= cfg_pat_src;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      scale_q <= `SCALE_RESET;
    else if (scale_we)
      scale_q <= scale_fx;
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [NA-1:0] ana_m_q, ana_s_q, ana_p_q;
  logic [ND-1:0] dig_m_q, dig_s_q;
  // No reset: the chain follows the pins through reset, so a clock
  // channel idling high gives no false edge once reset lifts
  always_ff @(posedge clk_sys)
  begin
    ana_m_q <= ana_in;
    ana_s_q <= ana_m_q;
    ana_p_q <= ana_s_q;
    dig_m_q <= dig_in;
    dig_s_q <= dig_m_q;
  end

  // ****************************************
  // Qualification
  // ****************************************
  logic [1:0]    ctx;
  logic [NA-1:0] clk_mask;
  logic [NA-1:0] ana_excl;
  logic          ana_ok, dig_ok;
  logic          clk_now, clk_old, edge_hit;
  logic          state_hit, pattern_hit, cand;

  assign ctx      = (32'(active_ctx) < NC) ? active_ctx : `CTX_A;
  assign clk_mask = NA'(1) << clk_ch_q[ctx];
  assign ana_excl = (type_q[ctx] == trig_pkg::TRIG_STATE)
                    ? clk_mask : '0;

  level_match #(.N(NA)) u_ana (
    .levels  (ana_s_q),
    .reqs    (ana_req_q[ctx]),
    .exclude (ana_excl),
    .use_or  (ana_or_q[ctx]),
    .result  (ana_ok)
  );
  level_match #(.N(ND)) u_dig (
    .levels  (dig_s_q),
    .reqs    (dig_req_q[ctx]),
    .exclude ('0),
    .use_or  (dig_or_q[ctx]),
    .result  (dig_ok)
  );

  assign clk_now = |(ana_s_q & clk_mask);
  assign clk_old = |(ana_p_q & clk_mask);
  always_comb
  begin
    case (edge_q[ctx])
      trig_pkg::EDGE_RISE: edge_hit = clk_now && !clk_old;
      trig_pkg::EDGE_FALL: edge_hit = !clk_now && clk_old;
      default:             edge_hit = clk_now != clk_old;
    endcase
  end
  // State needs both groups at the clock edge
  assign state_hit   = edge_hit && ana_ok && dig_ok;
  assign pattern_hit = (src_q[ctx] == trig_pkg::SRC_ANALOG)
                       ? ana_ok : dig_ok;
  assign cand = (type_q[ctx] == trig_pkg::TRIG_STATE)
                ? state_hit : pattern_hit;

  // ****************************************
  // Holdoff
  // ****************************************
  logic busy;
  logic accept;
  holdoff_timer #(.W(W)) u_hold (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .mode       (holdoff_mode),
    .bypass     (holdoff_bypass),
    .accept     (accept),
    .cand       (cand),
    .time_cyc   (holdoff_time_cyc),
    .events     (holdoff_events),
    .min_cyc    (holdoff_min_cyc),
    .max_cyc    (holdoff_max_cyc),
    .hscale_cyc (hscale_cyc),
    .scale_fx   (scale_q),
    .busy       (busy)
  );

  // ****************************************
  // Run modes and acceptance
  // ****************************************
  logic [W-1:0] wait_q;
  logic         real_ok, self_fire;
  // Pattern level stays true; holdoff alone paces repeats
  assign real_ok   = cand && !busy
                     && run_mode != trig_pkg::RUN_FREE;
  assign self_fire = (run_mode == trig_pkg::RUN_AUTO
                      && wait_q >= auto_timeout_cyc)
                  || (run_mode == trig_pkg::RUN_FREE
                      && wait_q >= W'(`FREE_RUN_CYCLES));
  // Normal mode fires on real_ok or force only
  assign accept    = real_ok || self_fire || force_req;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      wait_q <= '0;
    else if (accept)
      wait_q <= '0;
    else if (wait_q != '1)
      wait_q <= wait_q + 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      trig_out     <= 1'b0;
      trig_forced  <= 1'b0;
      holdoff_busy <= 1'b0;
      qual_state   <= 1'b0;
    end
    else
    begin
      trig_out     <= accept;
      trig_forced  <= force_req && !real_ok;
      holdoff_busy <= busy;
      qual_state   <= cand;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_force;
    @(posedge clk_sys) disable iff (!rst_n)
    force_req |=> trig_out;
  endproperty
  a_force: assert property (p_force)
    else $error("force did not trigger");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    (busy && !force_req && !self_fire) |=> !trig_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("trigger accepted during holdoff");

  property p_bypass;
    @(posedge clk_sys) disable iff (!rst_n)
    holdoff_bypass |=> !busy;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("holdoff active while bypassed");

  property p_free;
    @(posedge clk_sys) disable iff (!rst_n)
    (run_mode == trig_pkg::RUN_FREE && !force_req && !self_fire)
      |=> !trig_out;
  endproperty
  a_free: assert property (p_free)
    else $error("free run took a real trigger");

  property p_real;
    @(posedge clk_sys) disable iff (!rst_n)
    real_ok |=> trig_out;
  endproperty
  a_real: assert property (p_real)
    else $error("qualified trigger lost");

  sequence s_time_load;
    accept && holdoff_mode == trig_pkg::HO_TIME && !holdoff_bypass
    && holdoff_time_cyc == 32'h3;
  endsequence
  sequence s_busy_three;
    busy [*3] ##1 !busy;
  endsequence
  property p_time;
    @(posedge clk_sys) disable iff (!rst_n)
    s_time_load |=> s_busy_three;
  endproperty
  a_time: assert property (p_time)
    else $error("time holdoff length wrong");

  property p_edge;
    @(posedge clk_sys) disable iff (!rst_n)
    (type_q[ctx] == trig_pkg::TRIG_STATE && !edge_hit) |-> !cand;
  endproperty
  a_edge: assert property (p_edge)
    else $error("state trigger without clock edge");

  property p_qual;
    @(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> qual_state == $past(cand);
  endproperty
  a_qual: assert property (p_qual)
    else $error("qualification output stale");

  property p_forced_flag;
    @(posedge clk_sys) disable iff (!rst_n)
    (force_req && !real_ok) |=> trig_forced;
  endproperty
  a_forced_flag: assert property (p_forced_flag)
    else $error("forced trigger not flagged");

  property p_forced_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
    trig_forced |-> trig_out;
  endproperty
  a_forced_pulse: assert property (p_forced_pulse)
    else $error("forced flag without trigger");

  property p_normal_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
    (run_mode == trig_pkg::RUN_NORMAL && !real_ok && !force_req)
      |=> !trig_out;
  endproperty
  a_normal_quiet: assert property (p_normal_quiet)
    else $error("normal mode fired without trigger");

  property p_auto_fire;
    @(posedge clk_sys) disable iff (!rst_n)
    (run_mode == trig_pkg::RUN_AUTO && wait_q >= auto_timeout_cyc)
      |=> trig_out;
  endproperty
  a_auto_fire: assert property (p_auto_fire)
    else $error("auto mode timeout did not fire");

  property p_auto_wait;
    @(posedge clk_sys) disable iff (!rst_n)
    (run_mode == trig_pkg::RUN_AUTO && wait_q < auto_timeout_cyc
     && !real_ok && !force_req) |=> !trig_out;
  endproperty
  a_auto_wait: assert property (p_auto_wait)
    else $error("auto mode fired before timeout");

  property p_free_fire;
    @(posedge clk_sys) disable iff (!rst_n)
    (run_mode == trig_pkg::RUN_FREE && wait_q >= W'(`FREE_RUN_CYCLES))
      |=> trig_out;
  endproperty
  a_free_fire: assert property (p_free_fire)
    else $error("free run interval missed");

  property p_reload;
    @(posedge clk_sys) disable iff (!rst_n)
    (accept && !holdoff_bypass && holdoff_mode == trig_pkg::HO_TIME
     && holdoff_time_cyc != '0) |=> busy;
  endproperty
  a_reload: assert property (p_reload)
    else $error("holdoff not started by trigger");

  property p_random_load;
    @(posedge clk_sys) disable iff (!rst_n)
    (accept && !holdoff_bypass && holdoff_mode == trig_pkg::HO_RANDOM
     && holdoff_min_cyc != '0) |=> busy;
  endproperty
  a_random_load: assert property (p_random_load)
    else $error("random holdoff not started");

  property p_off_idle;
    @(posedge clk_sys) disable iff (!rst_n)
    (holdoff_mode == trig_pkg::HO_OFF) |=> !busy;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("holdoff active while off");

  property p_bypass_pass;
    @(posedge clk_sys) disable iff (!rst_n)
    ($past(holdoff_bypass) && holdoff_bypass && cand
     && run_mode != trig_pkg::RUN_FREE) |=> trig_out;
  endproperty
  a_bypass_pass: assert property (p_bypass_pass)
    else $error("bypassed holdoff blocked a trigger");
endmodule : trigger_qualification_holdoff

// ---- rtl/trig_map.svh ----
// Constants for the trigger qualification and holdoff block
// Functional notes
// - Each setting set exists per context: first stage, second stage, reset event.
// - Analog channels 1..4 hold high, low or ignore; ignore after reset.
// - State trigger excludes the clock channel from level qualification.
// - Levels combine by AND or OR per group; AND after reset.
// - State trigger clock edge is rising, falling or both; rising after reset.
// - Digital channels 0..15 hold high, low or ignore; ignore after reset.
// - Pattern trigger uses analog or digital group; analog after reset.
// - Auto mode self-triggers after a timeout; real trigger wins.
// - Normal mode acquires only on a qualifying trigger.
// - Free-run self-triggers after a short interval, ignoring real triggers.
// - Force starts one acquisition immediately, in any mode.
// - Holdoff blocks acceptance after each accepted trigger; the code blocks only real triggers, not force or self-triggers.
// - Holdoff is inactive for external, serial bus or sequence sources.
// - Holdoff modes: time, events, random, automatic, off.
// - Time holdoff waits the programmed period after the trigger.
// - Event holdoff accepts only after the programmed event count.
// - Random holdoff draws a new time between minimum and maximum.
// - Automatic holdoff derives its time from horizontal scale.
// - Automatic time is factor times scale; factor resets to 0.5.
`ifndef TRIG_MAP_SVH
`define TRIG_MAP_SVH
`define CTX_COUNT       3
`define CTX_A           2'h0
`define CTX_B           2'h1
`define CTX_RESET       2'h2
`define ANA_CHANNELS    4
`define DIG_CHANNELS    16
`define FREE_RUN_CYCLES 16'h0010
`define SCALE_FRAC_BITS 4
`define SCALE_RESET     16'h0008
`define LFSR_SEED       16'hace1
`endif

// ---- rtl/trig_pkg.sv ----
// Types for the trigger qualification and holdoff block
package trig_pkg;
  typedef enum logic [1:0] {LVL_IGNORE, LVL_HIGH, LVL_LOW} level_req_t;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_t;
  typedef enum logic [1:0] {RUN_AUTO, RUN_NORMAL, RUN_FREE} run_mode_t;
  typedef enum logic [2:0] {HO_OFF, HO_TIME, HO_EVENTS, HO_RANDOM,
                            HO_AUTO} holdoff_mode_t;
  typedef enum logic {TRIG_STATE, TRIG_PATTERN} trig_type_t;
  typedef enum logic {SRC_ANALOG, SRC_DIGITAL} pat_src_t;
endpackage : trig_pkg

// ---- rtl/level_match.sv ----
// Per-channel level match and group combine
`timescale 1ns/1ps
module level_match #(
  parameter int N = 4
) (
  input  wire logic [N-1:0]   levels,
  input  wire logic [2*N-1:0] reqs,
  input  wire logic [N-1:0]   exclude,
  input  wire logic           use_or,
  output logic                result
);
  logic [N-1:0] hit;
  logic [N-1:0] care;
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_ch
      assign care[i] = (reqs[2*i+:2] != 2'(trig_pkg::LVL_IGNORE))
                       && !exclude[i];
      assign hit[i]  = (reqs[2*i+:2] == 2'(trig_pkg::LVL_HIGH))
                       ? levels[i] : !levels[i];
    end
  endgenerate
  // Ignored channels are neutral for each operator
  assign result = use_or ? |(hit & care)
                         : &(hit | ~care);
endmodule : level_match

// ---- rtl/holdoff_timer.sv ----
// Holdoff timer: time, events, random, automatic
`timescale 1ns/1ps
`include "trig_map.svh"
module holdoff_timer #(
  parameter int W = 32
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire trig_pkg::holdoff_mode_t mode,
  input  wire logic                   bypass,
  input  wire logic                   accept,
  input  wire logic                   cand,
  input  wire logic [W-1:0]           time_cyc,
  input  wire logic [W-1:0]           events,
  input  wire logic [W-1:0]           min_cyc,
  input  wire logic [W-1:0]           max_cyc,
  input  wire logic [W-1:0]           hscale_cyc,
  input  wire logic [15:0]            scale_fx,
  output logic                        busy
);
  logic [W-1:0]  cnt_q;
  logic [15:0]   lfsr_q;
  logic [W-1:0]  span;
  logic [W-1:0]  rnd;
  logic [W+15:0] prod;
  logic [W-1:0]  load;
  assign span = max_cyc - min_cyc + 1'b1;
  assign rnd  = (max_cyc > min_cyc)
                ? min_cyc + (W'(lfsr_q) % span) : min_cyc;
  assign prod = hscale_cyc * scale_fx;
  always_comb
  begin
    case (mode)
      trig_pkg::HO_TIME:   load = time_cyc;
      trig_pkg::HO_EVENTS: load = events;
      trig_pkg::HO_RANDOM: load = rnd;
      trig_pkg::HO_AUTO:   load = W'(prod >> `SCALE_FRAC_BITS);
      default:             load = '0;
    endcase
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      lfsr_q <= `LFSR_SEED;
    else
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15]^lfsr_q[13]^lfsr_q[12]^lfsr_q[10]};
  end
  // Events mode counts candidates; time modes count cycles
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (bypass || mode == trig_pkg::HO_OFF)
      cnt_q <= '0;
    else if (accept)
      cnt_q <= load;
    else if (cnt_q != '0 && (mode != trig_pkg::HO_EVENTS || cand))
      cnt_q <= cnt_q - 1'b1;
  end
  assign busy = (cnt_q != '0);
endmodule : holdoff_timer

// ---- tb/probe_channels.sv ----
// Model of the thresholded probe channels feeding the block
`timescale 1ns/1ps
module probe_channels (
  input  wire logic        clk_sys,
  input  wire logic [3:0]  ana_set,
  input  wire logic [15:0] dig_set,
  output logic [3:0]       ana_in,
  output logic [15:0]      dig_in
);
  // Levels change just after an edge, like a real comparator output
  always_ff @(posedge clk_sys)
  begin
    ana_in <= ana_set;
    dig_in <= dig_set;
  end
endmodule : probe_channels

// ---- tb/trigger_qualification_holdoff_tb_top.sv ----
// Self-checking bench for trigger qualification and holdoff
`timescale 1ns/1ps
module trigger_qualification_holdoff_tb_top;
  typedef struct packed {
    logic [7:0] req;
    logic       use_or;
    logic [3:0] lv;
    logic       q;
  } qrow_t;
  typedef struct packed {
    trig_pkg::holdoff_mode_t m;
    logic                    byp;
    logic [7:0]              g;
  } hrow_t;
  logic                    clk_sys = 1'b0;
  logic                    rst_n = 1'b0;
  logic [3:0]              ana_set = 4'h0;
  logic [15:0]             dig_set = 16'h0000;
  logic [3:0]              ana_in;
  logic [15:0]             dig_in;
  logic                    cfg_we = 1'b0;
  logic [1:0]              cfg_ctx = 2'h0;
  logic [1:0]              cfg_clk_ch = 2'h0;
  logic [1:0]              active_ctx = 2'h0;
  trig_pkg::trig_type_t    cfg_type = trig_pkg::TRIG_PATTERN;
  logic [7:0]              cfg_ana_req = 8'h00;
  logic [31:0]             cfg_dig_req = 32'h0;
  logic                    cfg_ana_or = 1'b0;
  logic                    cfg_dig_or = 1'b0;
  trig_pkg::edge_sel_t     cfg_edge = trig_pkg::EDGE_RISE;
  trig_pkg::pat_src_t      cfg_pat_src = trig_pkg::SRC_ANALOG;
  trig_pkg::run_mode_t     run_mode = trig_pkg::RUN_NORMAL;
  logic                    force_req = 1'b0;
  logic                    holdoff_bypass = 1'b0;
  trig_pkg::holdoff_mode_t holdoff_mode = trig_pkg::HO_OFF;
  logic [31:0]             auto_timeout = 32'h100;
  logic                    scale_we = 1'b0;
  logic [15:0]             scale_fx = 16'h0008;
  logic                    trig_out;
  logic                    trig_forced;
  logic                    holdoff_busy;
  logic                    qual_state;
  logic [7:0]              g;
  logic [7:0]              c1;
  logic [7:0]              c2;
  int                      n_fail = 0;
  int                      n_compared = 0;
  qrow_t qrows [7] = '{'{8'h00, 1'b0, 4'h0, 1'b1}, '{8'h00, 1'b1, 4'h0, 1'b0},
    '{8'h05, 1'b0, 4'h3, 1'b1}, '{8'h05, 1'b0, 4'h1, 1'b0},
    '{8'h09, 1'b1, 4'h0, 1'b1}, '{8'h09, 1'b1, 4'h2, 1'b0},
    '{8'haa, 1'b0, 4'h0, 1'b1}};
  // Time 3, events 2, scale 16 at factor one half
  hrow_t hrows [5] = '{'{trig_pkg::HO_OFF, 1'b0, 8'h01},
    '{trig_pkg::HO_TIME, 1'b0, 8'h04}, '{trig_pkg::HO_EVENTS, 1'b0, 8'h03},
    '{trig_pkg::HO_TIME, 1'b1, 8'h01}, '{trig_pkg::HO_AUTO, 1'b0, 8'h09}};

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  probe_channels i_probe (.clk_sys(clk_sys), .ana_set(ana_set),
    .dig_set(dig_set), .ana_in(ana_in), .dig_in(dig_in));

  trigger_qualification_holdoff i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ana_in(ana_in), .dig_in(dig_in),
    .cfg_we(cfg_we), .cfg_ctx(cfg_ctx), .cfg_type(cfg_type),
    .cfg_ana_req(cfg_ana_req), .cfg_dig_req(cfg_dig_req),
    .cfg_ana_or(cfg_ana_or), .cfg_dig_or(cfg_dig_or), .cfg_edge(cfg_edge),
    .cfg_clk_ch(cfg_clk_ch), .cfg_pat_src(cfg_pat_src),
    .active_ctx(active_ctx), .run_mode(run_mode), .force_req(force_req),
    .holdoff_bypass(holdoff_bypass), .holdoff_mode(holdoff_mode),
    .holdoff_time_cyc(32'h3), .holdoff_events(32'h2),
    .holdoff_min_cyc(32'h4), .holdoff_max_cyc(32'h8), .hscale_cyc(32'h10),
    .scale_we(scale_we), .scale_fx(scale_fx),
    .auto_timeout_cyc(auto_timeout), .trig_out(trig_out),
    .trig_forced(trig_forced), .holdoff_busy(holdoff_busy),
    .qual_state(qual_state));

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic cfg(input logic [1:0] ctx, input trig_pkg::trig_type_t t,
                     input logic [7:0] ar, input logic ao);
    cfg_ctx = ctx;
    cfg_type = t;
    cfg_ana_req = ar;
    cfg_ana_or = ao;
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
    cyc(1);
  endtask : cfg

  // Cycles between two trigger pulses; bounded so a stuck block ends the run
  task automatic gap(output logic [7:0] n);
    int i;
    i = 0;
    while (trig_out !== 1'b1 && i < 300)
    begin
      cyc(1);
      i++;
    end
    cyc(1);
    n = 8'h01;
    while (trig_out !== 1'b1 && n < 8'hff)
    begin
      cyc(1);
      n++;
    end
    if (i >= 300 || n == 8'hff)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, n, 8'h00);
      close_out();
    end
  endtask : gap

  task automatic count_trig(input int n, output logic [7:0] c);
    c = 8'h00;
    repeat (n)
    begin
      cyc(1);
      if (trig_out === 1'b1)
        c++;
    end
  endtask : count_trig

  task automatic gap2(output logic [7:0] n);
    gap(n);
    gap(n);
  endtask : gap2

  initial
  begin
    cyc(3);
    chk({5'h00, trig_out, holdoff_busy, qual_state}, 8'h00);
    cyc(4);
    rst_n = 1'b1;
    cyc(1);
    chk({6'h00, trig_out, trig_forced}, 8'h00);
    $display("reset test done");
    foreach (qrows[i])
    begin
      cfg(2'h0, trig_pkg::TRIG_PATTERN, qrows[i].req, qrows[i].use_or);
      ana_set = qrows[i].lv;
      cyc(6);
      chk({7'h00, qual_state}, {7'h00, qrows[i].q});
    end
    $display("level table done");
    cfg_pat_src = trig_pkg::SRC_DIGITAL;
    cfg_dig_req = 32'h4000_0000;
    cfg(2'h0, trig_pkg::TRIG_PATTERN, 8'h00, 1'b1);
    dig_set = 16'h8000;
    cyc(6);
    chk({7'h00, qual_state}, 8'h01);
    dig_set = 16'h0000;
    cyc(6);
    chk({7'h00, qual_state}, 8'h00);
    cfg_pat_src = trig_pkg::SRC_ANALOG;
    cfg(2'h1, trig_pkg::TRIG_PATTERN, 8'h02, 1'b0);
    cfg(2'h2, trig_pkg::TRIG_PATTERN, 8'h00, 1'b0);
    ana_set = 4'h1;
    for (int k = 0; k < 3; k++)
    begin
      active_ctx = 2'(k);
      cyc(6);
      chk({7'h00, qual_state}, {7'h00, k == 2});
    end
    $display("source and context test done");
    active_ctx = 2'h0;
    cyc(4);
    force_req = 1'b1;
    cyc(1);
    force_req = 1'b0;
    chk({6'h00, trig_out, trig_forced}, 8'h03);
    cyc(1);
    chk({6'h00, trig_out, trig_forced}, 8'h00);
    count_trig(60, c1);
    chk(c1, 8'h00);
    auto_timeout = 32'h28;
    run_mode = trig_pkg::RUN_AUTO;
    gap2(g);
    chk({7'h00, g >= 8'h28 && g <= 8'h2a}, 8'h01);
    active_ctx = 2'h2;
    gap2(g);
    chk(g, 8'h01);
    run_mode = trig_pkg::RUN_FREE;
    gap2(g);
    chk({7'h00, g >= 8'h10 && g <= 8'h12}, 8'h01);
    $display("run mode test done");
    run_mode = trig_pkg::RUN_NORMAL;
    foreach (hrows[i])
    begin
      holdoff_mode = hrows[i].m;
      holdoff_bypass = hrows[i].byp;
      gap2(g);
      chk(g, hrows[i].g);
    end
    holdoff_bypass = 1'b0;
    scale_fx = 16'h0010;
    scale_we = 1'b1;
    cyc(1);
    scale_we = 1'b0;
    gap2(g);
    chk(g, 8'h11);
    cyc(1);
    chk({7'h00, holdoff_busy}, 8'h01);
    holdoff_mode = trig_pkg::HO_RANDOM;
    repeat (4)
    begin
      gap(g);
      chk({7'h00, g >= 8'h05 && g <= 8'h09}, 8'h01);
    end
    $display("holdoff test done");
    holdoff_mode = trig_pkg::HO_OFF;
    active_ctx = 2'h0;
    cfg_dig_req = 32'h0;
    // Clock channel asks for low yet must still fire on its edge
    for (int e = 0; e < 3; e++)
    begin
      cfg_edge = trig_pkg::edge_sel_t'(e);
      cfg(2'h0, trig_pkg::TRIG_STATE, 8'h06, 1'b0);
      ana_set = 4'h2;
      cyc(8);
      ana_set = 4'h3;
      count_trig(8, c1);
      ana_set = 4'h2;
      count_trig(8, c2);
      chk({c1[3:0], c2[3:0]}, {3'h0, e != 1, 3'h0, e != 0});
    end
    ana_set = 4'h1;
    count_trig(8, c1);
    ana_set = 4'h0;
    count_trig(8, c2);
    chk(c1 + c2, 8'h00);
    $display("state trigger test done");
    close_out();
  end
endmodule : trigger_qualification_holdoff_tb_top
